/* shared/mfia_pkg.sv */
// constants, register map and carrier types of the interrupt aggregator
package mfia_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_SRC_FLAG = 8'h08;
  localparam logic [7:0] OFF_REQ_FLAG = 8'h0c;
  localparam logic [7:0] OFF_ADC_BOUND = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // widths
  localparam int N_SRC = 15;
  localparam int N_REQ = 8;
  localparam int VEC_W = 3;
  localparam int ADC_W = 12;
  localparam int EN_W = 17;

  // member source flag positions
  localparam int SRC_HALL_A = 0;
  localparam int SRC_ADC_A = 3;
  localparam int SRC_ADC_B = 4;
  localparam int SRC_PWM_D0 = 5;
  localparam int SRC_PWM_P = 8;
  localparam int SRC_CAP_O = 9;
  localparam int SRC_CAP_C = 10;
  localparam int SRC_TMR0_P = 11;
  localparam int SRC_TMR0_A = 12;
  localparam int SRC_TMR1_P = 13;
  localparam int SRC_TMR1_A = 14;

  // request flag positions, also the vector numbers; lower wins
  localparam logic [2:0] REQ_HALL = 3'h0;
  localparam logic [2:0] REQ_MF1 = 3'h1;
  localparam logic [2:0] REQ_MF2 = 3'h2;
  localparam logic [2:0] REQ_MF3 = 3'h3;
  localparam logic [2:0] REQ_MF4 = 3'h4;
  localparam logic [2:0] REQ_EEPROM = 3'h5;
  localparam logic [2:0] REQ_LVD = 3'h6;
  localparam logic [2:0] REQ_IIC = 3'h7;

  // group membership over the source flags
  localparam logic [14:0] MASK_HALL = 15'h0007;
  localparam logic [14:0] MASK_ADC = 15'h0018;
  localparam logic [14:0] MASK_PWM = 15'h01e0;
  localparam logic [14:0] MASK_CAP = 15'h0600;
  localparam logic [14:0] MASK_TMR = 15'h7800;

  // adc bound register field positions
  localparam int BOUND_LO_LSB = 0;
  localparam int BOUND_HI_LSB = 16;

  // reset values
  localparam logic RST_GIE = 1'b0;
  localparam logic [16:0] RST_EN = 17'h00000;
  localparam logic [11:0] RST_BOUND_LO = 12'h000;
  localparam logic [11:0] RST_BOUND_HI = 12'hfff;

  // enable register layout, bit 0 at the right
  typedef struct packed {
    logic adc_lo_cmp;
    logic adc_hi_cmp;
    logic tmr1_a;
    logic tmr1_p;
    logic tmr0_a;
    logic tmr0_p;
    logic capture;
    logic adc_b;
    logic adc_a;
    logic [7:0] req;
  } mfia_en_t;

  // single-cycle event pulses from peripherals on pclk
  typedef struct packed {
    logic [2:0] pwm_duty;
    logic pwm_period;
    logic cap_overflow;
    logic cap_compare;
    logic [1:0] tmr_p;
    logic [1:0] tmr_a;
    logic eeprom_done;
    logic serial_done;
  } mfia_evt_t;

  // vector call towards the program sequencer
  typedef struct packed {
    logic req;
    logic [2:0] vector;
  } mfia_call_t;

endpackage : mfia_pkg

/* hw/mfia_ctrl.sv */
// interrupt aggregator: flags, enables, vector call, wake, apb registers
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps

module mfia_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] hall_pin,
  input wire logic low_supply_pin,
  input wire mfia_pkg::mfia_evt_t evt,
  input wire logic adc_eoc,
  input wire logic [11:0] adc_result,
  input wire logic stack_full,
  input wire logic core_sleep,
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  output mfia_pkg::mfia_call_t call,
  output logic wake
);

  // lowest set index wins
  function automatic logic [2:0] pick_first(input logic [7:0] p);
    logic [2:0] v;
    logic found;
    v = 3'h0;
    found = 1'b0;
    for (int i = 0; i < mfia_pkg::N_REQ; i++)
    begin
      if (p[i] && !found)
      begin
        v = 3'(i);
        found = 1'b1;
      end
    end
    return v;
  endfunction : pick_first

  // does any enabled member of a group set this cycle
  function automatic logic group_hit(input logic [14:0] set,
                                     input logic [14:0] en,
                                     input logic [14:0] mask);
    return |(set & en & mask);
  endfunction : group_hit

  mfia_pkg::mfia_en_t en;
  logic gie;
  logic [14:0] src_flag;
  logic [7:0] req_flag;
  logic [11:0] bound_lo;
  logic [11:0] bound_hi;
  logic [11:0] adc_res;
  logic cmp_pend;
  logic [2:0] hall_s1;
  logic [2:0] hall_s2;
  logic [2:0] hall_s3;
  logic lvd_s1;
  logic lvd_s2;
  logic lvd_s3;
  logic [22:0] prev_flags;
  logic wr;
  logic [2:0] hall_edge;
  logic lvd_edge;
  logic adc_lim_hit;
  logic [14:0] src_set;
  logic [14:0] src_en;
  logic [7:0] req_set;
  logic [7:0] pending;
  logic [14:0] next_src;
  logic [7:0] next_req;
  logic [31:0] next_rdata;
  logic next_err;

  // write takes effect at the access edge, pready is high there
  assign wr = psel & penable & pwrite & pready;

  // pins are outside the clock domain; two flops before any use.
  // limitation: pclk must keep running in sleep for pin flags to set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hall_s1 <= 3'h0;
      hall_s2 <= 3'h0;
      hall_s3 <= 3'h0;
      lvd_s1 <= 1'b0;
      lvd_s2 <= 1'b0;
      lvd_s3 <= 1'b0;
    end
    else
    begin
      hall_s1 <= hall_pin;
      hall_s2 <= hall_s1;
      hall_s3 <= hall_s2;
      lvd_s1 <= low_supply_pin;
      lvd_s2 <= lvd_s1;
      lvd_s3 <= lvd_s2;
    end
  end

  // edges read only the second and third stages
  assign hall_edge = hall_s2 ^ hall_s3;
  assign lvd_edge = lvd_s2 & ~lvd_s3;

  // converter result held one cycle for the boundary compare
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adc_res <= 12'h000;
      cmp_pend <= 1'b0;
    end
    else
    begin
      if (adc_eoc)
      begin
        adc_res <= adc_result;
      end
      cmp_pend <= adc_eoc;
    end
  end

  // compare after end of conversion, each bound separately enabled
  assign adc_lim_hit = cmp_pend &
    ((en.adc_hi_cmp & (adc_res > bound_hi)) |
     (en.adc_lo_cmp & (adc_res < bound_lo)));

  // member source set events
  always_comb
  begin
    src_set = 15'h0000;
    src_set[mfia_pkg::SRC_HALL_A +: 3] = hall_edge;
    src_set[mfia_pkg::SRC_ADC_A] = adc_eoc;
    src_set[mfia_pkg::SRC_ADC_B] = adc_lim_hit;
    src_set[mfia_pkg::SRC_PWM_D0 +: 3] = evt.pwm_duty;
    src_set[mfia_pkg::SRC_PWM_P] = evt.pwm_period;
    src_set[mfia_pkg::SRC_CAP_O] = evt.cap_overflow;
    src_set[mfia_pkg::SRC_CAP_C] = evt.cap_compare;
    src_set[mfia_pkg::SRC_TMR0_P] = evt.tmr_p[0];
    src_set[mfia_pkg::SRC_TMR0_A] = evt.tmr_a[0];
    src_set[mfia_pkg::SRC_TMR1_P] = evt.tmr_p[1];
    src_set[mfia_pkg::SRC_TMR1_A] = evt.tmr_a[1];
  end

  // member enables; hall and pwm members are gated only by the group
  always_comb
  begin
    src_en = 15'h0000;
    src_en[mfia_pkg::SRC_HALL_A +: 3] = 3'h7;
    src_en[mfia_pkg::SRC_ADC_A] = en.adc_a;
    src_en[mfia_pkg::SRC_ADC_B] = en.adc_b;
    src_en[mfia_pkg::SRC_PWM_D0 +: 4] = 4'hf;
    src_en[mfia_pkg::SRC_CAP_O] = en.capture;
    src_en[mfia_pkg::SRC_CAP_C] = en.capture;
    src_en[mfia_pkg::SRC_TMR0_P] = en.tmr0_p;
    src_en[mfia_pkg::SRC_TMR0_A] = en.tmr0_a;
    src_en[mfia_pkg::SRC_TMR1_P] = en.tmr1_p;
    src_en[mfia_pkg::SRC_TMR1_A] = en.tmr1_a;
  end

  // request set events: five groups then three independent requests
  always_comb
  begin
    req_set[mfia_pkg::REQ_HALL] =
      group_hit(src_set, src_en, mfia_pkg::MASK_HALL);
    req_set[mfia_pkg::REQ_MF1] =
      group_hit(src_set, src_en, mfia_pkg::MASK_ADC);
    req_set[mfia_pkg::REQ_MF2] =
      group_hit(src_set, src_en, mfia_pkg::MASK_PWM);
    req_set[mfia_pkg::REQ_MF3] =
      group_hit(src_set, src_en, mfia_pkg::MASK_CAP);
    req_set[mfia_pkg::REQ_MF4] =
      group_hit(src_set, src_en, mfia_pkg::MASK_TMR);
    req_set[mfia_pkg::REQ_EEPROM] = evt.eeprom_done;
    req_set[mfia_pkg::REQ_LVD] = lvd_edge;
    req_set[mfia_pkg::REQ_IIC] = evt.serial_done;
  end

  // member flags: software writes them, service leaves them; set wins
  always_comb
  begin
    next_src = src_flag;
    if (wr && paddr == mfia_pkg::OFF_SRC_FLAG)
    begin
      next_src = pwdata[14:0];
    end
    next_src = next_src | src_set;
  end

  // request flags: service clears the shown vector's flag; set wins
  always_comb
  begin
    next_req = req_flag;
    if (wr && paddr == mfia_pkg::OFF_REQ_FLAG)
    begin
      next_req = pwdata[7:0];
    end
    if (irq_ack)
    begin
      next_req[call.vector] = 1'b0;
    end
    next_req = next_req | req_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_flag <= 15'h0000;
      req_flag <= 8'h00;
    end
    else
    begin
      src_flag <= next_src;
      req_flag <= next_req;
    end
  end

  // global enable: service clears, interrupt return sets, then software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gie <= mfia_pkg::RST_GIE;
    end
    else if (irq_ack)
    begin
      gie <= 1'b0;
    end
    else if (return_from_interrupt)
    begin
      gie <= 1'b1;
    end
    else if (wr && paddr == mfia_pkg::OFF_CTRL)
    begin
      gie <= pwdata[0];
    end
  end

  // software configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en <= mfia_pkg::RST_EN;
      bound_lo <= mfia_pkg::RST_BOUND_LO;
      bound_hi <= mfia_pkg::RST_BOUND_HI;
    end
    else if (wr)
    begin
      if (paddr == mfia_pkg::OFF_ENABLE)
      begin
        en <= pwdata[mfia_pkg::EN_W-1:0];
      end
      if (paddr == mfia_pkg::OFF_ADC_BOUND)
      begin
        bound_lo <= pwdata[mfia_pkg::BOUND_LO_LSB +: mfia_pkg::ADC_W];
        bound_hi <= pwdata[mfia_pkg::BOUND_HI_LSB +: mfia_pkg::ADC_W];
      end
    end
  end

  // a flag stays set until serviced, but is pending only while its request enable is on
  assign pending = req_flag & en.req;

  // call drops the cycle after the ack so one request is never taken twice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      call <= '0;
    end
    else
    begin
      call.req <= gie & ~stack_full & (|pending) & ~irq_ack;
      call.vector <= pick_first(pending);
    end
  end

  // wake on any flag rising, blind to enables; a preset flag cannot rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_flags <= 23'h000000;
      wake <= 1'b0;
    end
    else
    begin
      prev_flags <= {req_flag, src_flag};
      wake <= core_sleep & (|({req_flag, src_flag} & ~prev_flags));
    end
  end

  // read data and error decided in the setup cycle, zero wait states
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
      mfia_pkg::OFF_CTRL: next_rdata[0] = gie;
      mfia_pkg::OFF_ENABLE: next_rdata[mfia_pkg::EN_W-1:0] = en;
      mfia_pkg::OFF_SRC_FLAG: next_rdata[14:0] = src_flag;
      mfia_pkg::OFF_REQ_FLAG: next_rdata[7:0] = req_flag;
      mfia_pkg::OFF_ADC_BOUND:
      begin
        next_rdata[mfia_pkg::BOUND_LO_LSB +: mfia_pkg::ADC_W] = bound_lo;
        next_rdata[mfia_pkg::BOUND_HI_LSB +: mfia_pkg::ADC_W] = bound_hi;
      end
      mfia_pkg::OFF_STATUS:
      begin
        next_rdata[0] = call.req;
        next_rdata[3:1] = call.vector;
        next_rdata[4] = stack_full;
        next_rdata[15:8] = pending;
      end
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      if (psel && !penable)
      begin
        prdata <= next_rdata;
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_SERVICE_CLEARS_GIE: assert property (
    irq_ack |=> !gie)
    else $error("global enable survived a service");

  AST_RETURN_FROM_INTERRUPT_SETS_GIE: assert property (
    return_from_interrupt && !irq_ack |=> gie)
    else $error("interrupt return did not set global enable");

  AST_NO_CALL_WITHOUT_GIE: assert property (
    !gie |=> !call.req)
    else $error("call raised with global enable low");

  AST_STACK_FULL_BLOCKS: assert property (
    stack_full |=> !call.req)
    else $error("call raised while stack full");

  AST_TIMER_SETS_GROUP: assert property (
    evt.tmr_p[0] && en.tmr0_p |=> req_flag[mfia_pkg::REQ_MF4])
    else $error("timer p match did not set its group flag");

  AST_EOC_FLAG: assert property (
    adc_eoc |=> src_flag[mfia_pkg::SRC_ADC_A])
    else $error("end of conversion flag not set");

  AST_ADC_LIMIT: assert property (
    adc_eoc && en.adc_hi_cmp && adc_result > bound_hi ##1
    $stable(en) && $stable(bound_hi) |=> src_flag[mfia_pkg::SRC_ADC_B])
    else $error("high bound compare flag not set");

  AST_HALL_EDGE: assert property (
    hall_s2[0] != hall_s3[0] |=> src_flag[mfia_pkg::SRC_HALL_A])
    else $error("hall transition not flagged");

  AST_EEPROM_SERVICE: assert property (
    irq_ack && call.vector == mfia_pkg::REQ_EEPROM && !evt.eeprom_done &&
    !wr |=> !req_flag[mfia_pkg::REQ_EEPROM])
    else $error("eeprom flag not cleared on service");

  AST_MEMBERS_KEPT: assert property (
    irq_ack && !wr |=> (src_flag & $past(src_flag)) == $past(src_flag))
    else $error("service disturbed member flags");

  AST_WAKE_ON_RISE: assert property (
    core_sleep && (|({req_flag, src_flag} & ~prev_flags)) |=> wake)
    else $error("flag rise during sleep gave no wake");

  AST_PRIORITY: assert property (
    gie && !stack_full && !irq_ack && pending[mfia_pkg::REQ_HALL] |=>
    call.req && call.vector == mfia_pkg::REQ_HALL)
    else $error("highest priority request not chosen");

  COV_CALL_TAKEN: cover property (call.req ##1 irq_ack);
  COV_RETURN: cover property (irq_ack ##[1:20] return_from_interrupt);
  COV_WAKE: cover property (core_sleep && wake);
  COV_ADC_LIMIT: cover property (adc_lim_hit);

endmodule : mfia_ctrl

/* verif/mfia_core_model.sv */
// core model: takes vector calls and returns from service
`timescale 1ns/1ps
module mfia_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire mfia_pkg::mfia_call_t call,
  input wire logic [3:0] lat,
  input wire logic use_return_from_interrupt,
  output logic irq_ack,
  output logic return_from_interrupt
);
  logic [3:0] wait_cnt;
  logic [3:0] ret_cnt;

  // one ack per call, after lat cycles of a standing call
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else
    begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
      if (call.req && !irq_ack && wait_cnt >= lat)
        irq_ack <= 1'b1;
      else if (call.req && !irq_ack)
        wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // interrupt return five cycles after service, or a plain return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      return_from_interrupt <= 1'b0;
      ret_cnt <= 4'h0;
    end
    else
    begin
      return_from_interrupt <= (ret_cnt == 4'h1) && use_return_from_interrupt;
      if (irq_ack)
        ret_cnt <= 4'h4;
      else if (ret_cnt != 4'h0)
        ret_cnt <= ret_cnt - 4'h1;
    end
  end
endmodule : mfia_core_model

/* verif/tb.sv */
// self-checking bench of the interrupt aggregator
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] hall_pin;
  logic low_supply_pin, adc_eoc, stack_full, core_sleep, wake;
  logic [11:0] adc_result;
  logic irq_ack, return_from_interrupt, use_return_from_interrupt;
  logic [3:0] lat;
  mfia_pkg::mfia_evt_t evt;
  mfia_pkg::mfia_call_t call;
  logic [35:0] bus_q [$];
  logic [2:0] vec_q [$];
  int err_count = 0, check_count = 0, wake_count = 0, cycles = 0;
  int seed = 32'h2d608ec6;
  // source flag bit and vector of stimulus k, -1 for no source flag
  localparam int SRC_POS [15] = '{-1,-1,12,14,11,13,10,9,8,5,6,7,3,0,-1};
  localparam int REQ_OF [15] = '{7,5,4,4,4,4,3,3,2,2,2,2,1,0,6};

  mfia_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hall_pin(hall_pin), .low_supply_pin(low_supply_pin), .evt(evt),
    .adc_eoc(adc_eoc), .adc_result(adc_result), .stack_full(stack_full),
    .core_sleep(core_sleep), .irq_ack(irq_ack),
    .return_from_interrupt(return_from_interrupt), .call(call),
    .wake(wake));

  mfia_core_model core (.pclk(pclk), .presetn(presetn), .call(call),
    .lat(lat), .use_return_from_interrupt(use_return_from_interrupt), .irq_ack(irq_ack),
    .return_from_interrupt(return_from_interrupt));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // finished transfers and services against the notes; timeout
  always @(posedge pclk)
  begin
    if (presetn && psel && penable && pready === 1'b1)
      check({3'h0, pslverr, pwrite ? 32'h0 : prdata}, bus_q.pop_front());
    if (presetn && irq_ack === 1'b1)
      check({33'h0, call.vector},
        vec_q.size() > 0 ? {33'h0, vec_q.pop_front()} : 36'hf);
    if (wake === 1'b1)
      wake_count++;
    cycles++;
    // whole run needs about 850 cycles
    if (cycles > 20000)
    begin
      err_count++;
      results();
    end
  end

  // one apb transfer; bus stays selected so the next may follow at once
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic e = 1'b0);
    bus_q.push_back({3'h0, e, w ? 32'h0 : d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
  endtask : xfer

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle

  // stimulus k: event pulse, end of conversion, hall or supply pin
  task automatic fire(input int k);
    if (k < 12)
      evt <= 12'h1 << k;
    else if (k == 12)
      adc_eoc <= 1'b1;
    else if (k == 13)
      hall_pin[0] <= ~hall_pin[0];
    else
      low_supply_pin <= 1'b1;
    @(posedge pclk);
    evt <= '0;
    adc_eoc <= 1'b0;
    repeat (5) @(posedge pclk);
    low_supply_pin <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : fire

  // waits out pending services plus the return
  task automatic wait_acks();
    for (int i = 0; i < 60 && vec_q.size() > 0; i++)
      @(posedge pclk);
    repeat (8) @(posedge pclk);
  endtask : wait_acks

  function automatic logic [31:0] src_mask(input int k);
    return SRC_POS[k] < 0 ? 32'h0 : 32'h1 << SRC_POS[k];
  endfunction : src_mask

  initial
  begin
    int w0;
    logic [31:0] v;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {hall_pin, low_supply_pin, adc_eoc, adc_result} = '0;
    {stack_full, core_sleep, evt} = '0;
    lat = 4'h1;
    use_return_from_interrupt = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped place, read-only status
    xfer(0, mfia_pkg::OFF_CTRL, 0);
    xfer(0, mfia_pkg::OFF_ENABLE, 0);
    xfer(0, mfia_pkg::OFF_SRC_FLAG, 0);
    xfer(0, mfia_pkg::OFF_REQ_FLAG, 0);
    xfer(0, mfia_pkg::OFF_ADC_BOUND, 32'h0fff0000);
    xfer(1, 8'h18, 32'hffffffff, 1);
    xfer(0, 8'h18, 0, 1);
    xfer(1, mfia_pkg::OFF_STATUS, 32'hffff);
    xfer(0, mfia_pkg::OFF_STATUS, 0);
    v = $random(seed) & 32'h1ffff;
    xfer(1, mfia_pkg::OFF_ENABLE, v);
    xfer(0, mfia_pkg::OFF_ENABLE, v);
    // flags latch with global enable off; wake on each rise
    xfer(1, mfia_pkg::OFF_ENABLE, 32'h7f00);
    idle();
    core_sleep <= 1'b1;
    adc_result <= 12'h800;
    for (int k = 0; k < 15; k++)
    begin
      w0 = wake_count;
      fire(k);
      xfer(0, mfia_pkg::OFF_SRC_FLAG, src_mask(k));
      xfer(0, mfia_pkg::OFF_REQ_FLAG, 32'h1 << REQ_OF[k]);
      xfer(1, mfia_pkg::OFF_SRC_FLAG, 0);
      xfer(1, mfia_pkg::OFF_REQ_FLAG, 0);
      idle();
      check(36'(wake_count - w0), 36'h1);
    end
    // preset flags mute the wake
    xfer(1, mfia_pkg::OFF_SRC_FLAG, 32'h7fff);
    xfer(1, mfia_pkg::OFF_REQ_FLAG, 32'hff);
    idle();
    repeat (2) @(posedge pclk);
    w0 = wake_count;
    fire(4);
    check(36'(wake_count - w0), 36'h0);
    core_sleep <= 1'b0;
    xfer(1, mfia_pkg::OFF_SRC_FLAG, 0);
    xfer(1, mfia_pkg::OFF_REQ_FLAG, 0);
    // every vector serviced, group cleared, member kept
    xfer(1, mfia_pkg::OFF_ENABLE, 32'h7fff);
    xfer(1, mfia_pkg::OFF_CTRL, 1);
    idle();
    for (int k = 0; k < 15; k++)
    begin
      lat <= 4'($random(seed)) & 4'h7;
      vec_q.push_back(REQ_OF[k]);
      fire(k);
      wait_acks();
      xfer(0, mfia_pkg::OFF_REQ_FLAG, 0);
      xfer(0, mfia_pkg::OFF_SRC_FLAG, src_mask(k));
      xfer(0, mfia_pkg::OFF_CTRL, 1);
      xfer(1, mfia_pkg::OFF_SRC_FLAG, 0);
      idle();
    end
    // simultaneous requests come in fixed order
    vec_q.push_back(mfia_pkg::REQ_EEPROM);
    vec_q.push_back(mfia_pkg::REQ_IIC);
    evt <= 12'h3;
    @(posedge pclk);
    evt <= '0;
    wait_acks();
    xfer(0, mfia_pkg::OFF_REQ_FLAG, 0);
    idle();
    // full stack holds the request; plain return leaves gie low
    use_return_from_interrupt <= 1'b0;
    stack_full <= 1'b1;
    fire(4);
    repeat (10) @(posedge pclk);
    xfer(0, mfia_pkg::OFF_REQ_FLAG, 32'h10);
    idle();
    vec_q.push_back(mfia_pkg::REQ_MF4);
    stack_full <= 1'b0;
    wait_acks();
    xfer(0, mfia_pkg::OFF_CTRL, 0);
    xfer(1, mfia_pkg::OFF_SRC_FLAG, 0);
    // bound compare after end of conversion
    xfer(1, mfia_pkg::OFF_ADC_BOUND, 32'h0e000100);
    xfer(1, mfia_pkg::OFF_ENABLE, 32'h18300);
    idle();
    for (int i = 0; i < 3; i++)
    begin
      v = i == 0 ? 32'h100 + ($random(seed) & 32'h7ff) :
        (i == 1 ? 32'hf00 : 32'h050);
      adc_result <= v[11:0];
      fire(12);
      xfer(0, mfia_pkg::OFF_SRC_FLAG, i ? 32'h18 : 32'h8);
      xfer(1, mfia_pkg::OFF_SRC_FLAG, 0);
      idle();
    end
    results();
  end
endmodule : tb
